// ### design/prt_host.sv
`default_nettype none

module prt_fifo #(
  parameter int W     = prt_pkg::PIX_W,
  parameter int DEPTH = prt_pkg::FIFO_DEPTH
) (
  input  wire logic         core_clk,   // Core clock
  input  wire logic         rst_n,      // Synchronous reset, active low
  input  wire logic [W-1:0] in_data,    // Word to store
  input  wire logic         in_valid,   // Word offered
  output var  logic         in_ready,   // Room for a word
  output var  logic [W-1:0] out_data,   // Oldest word
  output var  logic         out_valid,  // Oldest word present
  input  wire logic         out_ready   // Oldest word taken
);

  localparam int AW = $clog2(DEPTH);

  // Pointers wrap by overflow, so the depth must be a power of two
  if ((DEPTH < 2) || ((1 << AW) != DEPTH) || (W < 1)) begin : g_bad_cfg
    $error("prt_fifo: depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    rdy;
    logic                    vld;
  } prt_fifo_st_t;

  prt_fifo_st_t q;
  prt_fifo_st_t d;

  logic push;
  logic pop;

  assign push      = in_valid && q.rdy;
  assign pop       = out_ready && q.vld;
  assign in_ready  = q.rdy;
  assign out_valid = q.vld;
  assign out_data  = q.mem[q.rp];

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp        = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    case ({push, pop})
      2'b10:   d.cnt = q.cnt + 1'b1;
      2'b01:   d.cnt = q.cnt - 1'b1;
      default: d.cnt = q.cnt;
    endcase
    // Flags come from the next count so ready and valid are never stale
    d.rdy = (d.cnt != (AW + 1)'(DEPTH));
    d.vld = (d.cnt != '0);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      q     <= '0;
      q.rdy <= 1'b1;
    end else begin
      q <= d;
    end
  end

endmodule : prt_fifo

// One raster axis: a position that wraps at the period and the windows
// decoded from it. Horizontal steps once per pixel, vertical once per line.
module prt_axis #(
  parameter int SYNC   = prt_pkg::H_SYNC,
  parameter int BLANK  = prt_pkg::H_BLANK,
  parameter int ACTIVE = prt_pkg::H_ACTIVE,
  parameter int FRONT  = prt_pkg::H_FRONT,
  parameter int PW     = $clog2(BLANK + ACTIVE + FRONT)
) (
  input  wire logic          core_clk,   // Core clock
  input  wire logic          rst_n,      // Synchronous reset, active low
  input  wire logic          step,       // Advance one position
  output var  logic [PW-1:0] pos,        // Current position
  output var  logic          at_end,     // Last position of the period
  output var  logic          in_sync,    // Position inside the sync pulse
  output var  logic          in_active   // Position inside the active area
);

  localparam int TOTAL = BLANK + ACTIVE + FRONT;

  if ((SYNC < 1) || (SYNC >= BLANK) || (ACTIVE < 1) || (FRONT < 1)) begin : g_bad_axis
    $error("prt_axis: sync must sit inside blanking and each span must be non-empty");
  end
  if (PW < $clog2(TOTAL)) begin : g_bad_pw
    $error("prt_axis: position width too small for the period");
  end

  typedef struct packed {
    logic [PW-1:0] pos;
  } prt_axis_st_t;

  prt_axis_st_t q;
  prt_axis_st_t d;

  assign pos       = q.pos;
  assign at_end    = (q.pos == PW'(TOTAL - 1));
  assign in_sync   = (q.pos < PW'(SYNC));
  assign in_active = (q.pos >= PW'(BLANK)) && (q.pos < PW'(BLANK + ACTIVE));

  always_comb begin
    d = q;
    if (step) begin
      if (at_end) begin
        d.pos = '0;
      end else begin
        d.pos = q.pos + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule : prt_axis

module prt_host #(
  parameter int PIX_DIV         = prt_pkg::PIX_CLK_DIV,
  parameter int H_ACTIVE        = prt_pkg::H_ACTIVE,
  parameter int H_SYNC          = prt_pkg::H_SYNC,
  parameter int H_BLANK         = prt_pkg::H_BLANK,
  parameter int H_FRONT         = prt_pkg::H_FRONT,
  parameter int V_ACTIVE        = prt_pkg::V_ACTIVE,
  parameter int V_SYNC          = prt_pkg::V_SYNC,
  parameter int V_BLANK         = prt_pkg::V_BLANK,
  parameter int V_FRONT         = prt_pkg::V_FRONT,
  parameter int RESET_CYCLES    = prt_pkg::PANEL_RESET_CYC,
  parameter bit HSYNC_ACT_HIGH  = 1'b0,
  parameter bit VSYNC_ACT_HIGH  = 1'b0,
  parameter int FIFO_DEPTH      = prt_pkg::FIFO_DEPTH
) (
  input  wire logic                     core_clk,         // Core clock, 100 MHz
  input  wire logic                     rst_n,            // Synchronous reset, active low
  input  wire logic [prt_pkg::PIX_W-1:0] pix_data,        // Pixel word, red 23:16, green 15:8, blue 7:0
  input  wire logic                     pix_valid,        // Pixel word offered
  output var  logic                     pix_ready,        // Pixel word accepted when valid
  output var  logic                     pixel_clock,      // Panel pixel clock
  output var  logic                     horizontal_sync,  // Panel line sync
  output var  logic                     vertical_sync,    // Panel frame sync
  output var  logic                     data_enable,      // Panel active pixel marker
  output var  logic [prt_pkg::PIX_W-1:0] rgb_data,        // Panel colour data
  output var  logic                     panel_reset_n,    // Panel system reset, active low
  output var  logic                     frame_start,      // One core cycle at each frame start
  output var  logic                     underrun          // Sticky: active pixel found no data
);

  localparam int H_TOTAL = H_BLANK + H_ACTIVE + H_FRONT;
  localparam int V_TOTAL = V_BLANK + V_ACTIVE + V_FRONT;
  localparam int PIX_KHZ = (prt_pkg::CORE_CLK_HZ / 1000) / PIX_DIV;
  localparam int DW      = $clog2(PIX_DIV);
  localparam int HW      = $clog2(H_TOTAL);
  localparam int VW      = $clog2(V_TOTAL);
  localparam int RW      = $clog2(RESET_CYCLES + 1);

  // Refuse pixel rates, periods and front porches the panel cannot take
  if (PIX_DIV < 2) begin : g_bad_div
    $error("prt_host: pixel clock divider must be at least 2");
  end
  if ((PIX_KHZ < prt_pkg::PIX_CLK_MIN_KHZ) || (PIX_KHZ > prt_pkg::PIX_CLK_MAX_KHZ)) begin : g_bad_rate
    $error("prt_host: pixel clock rate out of range");
  end
  if ((H_TOTAL < prt_pkg::H_TOTAL_MIN) || (H_TOTAL > prt_pkg::H_TOTAL_MAX)) begin : g_bad_htotal
    $error("prt_host: line period out of range");
  end
  if ((H_FRONT < prt_pkg::H_FRONT_MIN) || (H_FRONT > prt_pkg::H_FRONT_MAX)) begin : g_bad_hfront
    $error("prt_host: line front porch out of range");
  end
  if ((H_SYNC < 1) || (H_SYNC >= H_BLANK)) begin : g_bad_hsync
    $error("prt_host: line sync must be shorter than line blanking");
  end
  if ((V_TOTAL < prt_pkg::V_TOTAL_MIN) || (V_TOTAL > prt_pkg::V_TOTAL_MAX)) begin : g_bad_vtotal
    $error("prt_host: frame period out of range");
  end
  if ((V_FRONT < prt_pkg::V_FRONT_MIN) || (V_FRONT > prt_pkg::V_FRONT_MAX)) begin : g_bad_vfront
    $error("prt_host: frame front porch out of range");
  end
  if ((V_SYNC < 1) || (V_SYNC >= V_BLANK)) begin : g_bad_vsync
    $error("prt_host: frame sync must be shorter than frame blanking");
  end
  if (RESET_CYCLES < 1) begin : g_bad_rst
    $error("prt_host: panel reset length must be at least one cycle");
  end

  localparam int CH_W = prt_pkg::PIX_W / 3;

  typedef enum logic [0:0] {
    PRT_WAIT = 1'b0,
    PRT_RUN  = 1'b1
  } prt_host_mode_t;

  typedef struct packed {
    logic [DW-1:0]             div;
    logic [RW-1:0]             rst_cnt;
    prt_host_mode_t            mode;
    logic                      pclk;
    logic                      hs;
    logic                      vs;
    logic                      de;
    logic [prt_pkg::PIX_W-1:0] rgb;
    logic                      prst_n;
    logic                      fstart;
    logic                      urun;
  } prt_host_st_t;

  prt_host_st_t q;
  prt_host_st_t d;

  logic [prt_pkg::PIX_W-1:0] fifo_data;
  logic                      fifo_valid;
  logic                      fifo_pop;
  logic                      adv;
  logic [HW-1:0]             hpos;
  logic [VW-1:0]             vpos;
  logic                      h_end;
  logic                      h_sync;
  logic                      v_sync;
  logic                      v_step;
  logic                      h_act;
  logic                      v_act;
  logic                      act;
  logic [prt_pkg::PIX_W-1:0] pix_out;

  prt_fifo #(
    .W     (prt_pkg::PIX_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_data   (pix_data),
    .in_valid  (pix_valid),
    .in_ready  (pix_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  prt_axis #(
    .SYNC   (H_SYNC),
    .BLANK  (H_BLANK),
    .ACTIVE (H_ACTIVE),
    .FRONT  (H_FRONT),
    .PW     (HW)
  ) u_hpos (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .step      (adv),
    .pos       (hpos),
    .at_end    (h_end),
    .in_sync   (h_sync),
    .in_active (h_act)
  );

  prt_axis #(
    .SYNC   (V_SYNC),
    .BLANK  (V_BLANK),
    .ACTIVE (V_ACTIVE),
    .FRONT  (V_FRONT),
    .PW     (VW)
  ) u_vpos (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .step      (v_step),
    .pos       (vpos),
    .at_end    (),
    .in_sync   (v_sync),
    .in_active (v_act)
  );

  // The panel samples on the rising pixel clock; outputs move one core
  // cycle after it, leaving the rest of the period as setup time.
  // Duty is one core cycle in the divide ratio, not a square wave.
  assign adv      = (q.mode == PRT_RUN) && (q.div == '0);
  assign v_step   = adv && h_end;
  assign act      = h_act && v_act;
  assign fifo_pop = adv && act;

  // Channels are gated one by one so blanking and underrun both send black
  for (genvar ch = 0; ch < 3; ch++) begin : g_chan
    assign pix_out[ch*CH_W +: CH_W] = (act && fifo_valid) ? fifo_data[ch*CH_W +: CH_W] : '0;
  end

  always_comb begin
    d        = q;
    d.fstart = 1'b0;
    // Divide the core clock down to the pixel clock
    if (q.div == DW'(PIX_DIV - 1)) begin
      d.div = '0;
    end else begin
      d.div = q.div + 1'b1;
    end
    d.pclk = (q.mode == PRT_RUN) && (d.div == '0);
    case (q.mode)
      PRT_WAIT: begin
        // Panel reset is held low for the full count before video starts
        d.prst_n = 1'b0;
        d.hs     = !HSYNC_ACT_HIGH;
        d.vs     = !VSYNC_ACT_HIGH;
        d.de     = 1'b0;
        d.rgb    = '0;
        if (q.rst_cnt == RW'(RESET_CYCLES - 1)) begin
          d.mode   = PRT_RUN;
          d.prst_n = 1'b1;
        end else begin
          d.rst_cnt = q.rst_cnt + 1'b1;
        end
      end
      PRT_RUN: begin
        if (adv) begin
          d.hs     = h_sync ~^ HSYNC_ACT_HIGH;
          d.vs     = v_sync ~^ VSYNC_ACT_HIGH;
          d.de     = act;
          d.rgb    = pix_out;
          d.urun   = q.urun || (act && !fifo_valid);
          d.fstart = (hpos == '0) && (vpos == '0);
        end
      end
      default: begin
        d.mode = PRT_WAIT;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      q    <= '0;
      q.hs <= !HSYNC_ACT_HIGH;
      q.vs <= !VSYNC_ACT_HIGH;
    end else begin
      q <= d;
    end
  end

  assign pixel_clock     = q.pclk;
  assign horizontal_sync = q.hs;
  assign vertical_sync   = q.vs;
  assign data_enable     = q.de;
  assign rgb_data        = q.rgb;
  assign panel_reset_n   = q.prst_n;
  assign frame_start     = q.fstart;
  assign underrun        = q.urun;

endmodule : prt_host

`default_nettype wire

// ### design/prt_pkg.sv
// Contract
// - Exactly 800 active pixels per line
// - Pixel clock between 29 and 38 MHz
// - Line lasts 1056 clocks, 1026 to 1086
// - Horizontal sync pulse lasts 30 clocks
// - Sync start to first pixel: 46 clocks
// - Last pixel to sync: 210, 180 to 240
// - Exactly 480 active lines per frame
// - Vertical sync pulse lasts 13 lines
// - Vertical sync start to first line: 23 lines
// - Last line to vertical sync: 22, 12 to 32
// - Panel reset held low at least 1 ms
`default_nettype none

package prt_pkg;

  localparam int CORE_CLK_HZ     = 100_000_000;
  localparam int PIX_CLK_MIN_KHZ = 29_000;
  localparam int PIX_CLK_MAX_KHZ = 38_000;
  localparam int PIX_CLK_DIV     = 3;

  localparam int H_ACTIVE        = 800;
  localparam int H_SYNC          = 30;
  localparam int H_BLANK         = 46;
  localparam int H_FRONT         = 210;
  localparam int H_FRONT_MIN     = 180;
  localparam int H_FRONT_MAX     = 240;
  localparam int H_TOTAL_MIN     = 1026;
  localparam int H_TOTAL_MAX     = 1086;

  localparam int V_ACTIVE        = 480;
  localparam int V_SYNC          = 13;
  localparam int V_BLANK         = 23;
  localparam int V_FRONT         = 22;
  localparam int V_FRONT_MIN     = 12;
  localparam int V_FRONT_MAX     = 32;
  localparam int V_TOTAL_MIN     = 515;
  localparam int V_TOTAL_MAX     = 535;

  localparam int PANEL_RESET_MS  = 1;
  localparam int PANEL_RESET_CYC = (PANEL_RESET_MS * (CORE_CLK_HZ / 1000));

  localparam int PIX_W           = 24;
  localparam int FIFO_DEPTH      = 32;

endpackage : prt_pkg

`default_nettype wire

// ### tb/prt_host_properties.sv
`default_nettype none
module prt_host_properties #(
  parameter int PIX_DIV      = 3,
  parameter int H_ACTIVE     = 800,
  parameter int H_SYNC       = 30,
  parameter int H_BLANK      = 46,
  parameter int H_FRONT      = 210,
  parameter int RESET_CYCLES = 20,
  parameter int V_ACTIVE     = 480,
  parameter int V_BLANK      = 23,
  parameter int V_FRONT      = 22
) (
  input wire logic        core_clk,         // Clock
  input wire logic        rst_n,            // Reset
  input wire logic        pixel_clock,      // Panel clock
  input wire logic        horizontal_sync,  // Line sync
  input wire logic        vertical_sync,    // Frame sync
  input wire logic        data_enable,      // Active pixel
  input wire logic [23:0] rgb_data,         // Colour
  input wire logic        panel_reset_n     // Panel reset
);
  timeunit 1ns;
  timeprecision 1ps;
  // Default polarities only; a high-active build needs these inverted
  wire logic hs_act = !horizontal_sync;
  logic      hp_q;
  logic      seen_q;
  int        h_q;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hp_q   <= 1'b0;
      seen_q <= 1'b0;
      h_q    <= 0;
    end else begin
      hp_q   <= hs_act;
      seen_q <= seen_q | (hs_act & !hp_q);
      h_q    <= (hs_act && !hp_q) ? 1 : h_q + 1;
    end
  end
  wire logic vs_act = !vertical_sync;
  logic      vp_q;
  logic      vseen_q;
  int        l_q;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      vp_q    <= 1'b0;
      vseen_q <= 1'b0;
      l_q     <= 0;
    end else begin
      vp_q    <= vs_act;
      vseen_q <= vseen_q | (vs_act & !vp_q);
      if (vs_act && !vp_q) l_q <= 0;
      else if (hs_act && !hp_q) l_q <= l_q + 1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_pix_low;
    !pixel_clock [*2];
  endsequence
  a_panel_reset_min: assert property ($rose(panel_reset_n) |-> h_q >= RESET_CYCLES)
    else $error("panel reset short");
  a_pixclk_period: assert property (pixel_clock |=> s_pix_low ##1 pixel_clock)
    else $error("pixel clock period");
  a_out_after_fall: assert property (!$stable({horizontal_sync, vertical_sync, data_enable, rgb_data})
    |-> $past(pixel_clock)) else $error("output moved mid period");
  a_hsync_width: assert property (seen_q && $fell(hs_act) |-> h_q == H_SYNC * PIX_DIV)
    else $error("line sync width");
  a_line_period: assert property (seen_q && $rose(hs_act) |-> h_q == (H_BLANK+H_ACTIVE+H_FRONT)*PIX_DIV)
    else $error("line period");
  a_hblank_len: assert property (seen_q && $rose(data_enable) |-> h_q == H_BLANK * PIX_DIV)
    else $error("blanking length");
  a_active_width: assert property (seen_q && $fell(data_enable) |-> h_q == (H_BLANK+H_ACTIVE)*PIX_DIV)
    else $error("active width");
  a_de_blanking: assert property (data_enable |-> horizontal_sync && vertical_sync)
    else $error("enable in sync");
  a_frame_period: assert property (vseen_q && $rose(vs_act) |-> l_q == V_BLANK + V_ACTIVE + V_FRONT - 1)
    else $error("frame period");
  a_active_lines: assert property ($rose(data_enable) |-> l_q >= V_BLANK && l_q < V_BLANK + V_ACTIVE)
    else $error("active line out of window");
endmodule : prt_host_properties
bind prt_host prt_host_properties #(.PIX_DIV(PIX_DIV), .H_ACTIVE(H_ACTIVE), .H_SYNC(H_SYNC),
  .H_BLANK(H_BLANK), .H_FRONT(H_FRONT), .RESET_CYCLES(RESET_CYCLES), .V_ACTIVE(V_ACTIVE), .V_BLANK(V_BLANK),
  .V_FRONT(V_FRONT)) u_props (.core_clk, .rst_n,
  .pixel_clock, .horizontal_sync, .vertical_sync, .data_enable, .rgb_data, .panel_reset_n);
`default_nettype wire

// ### tb/prt_panel_model.sv
`default_nettype none
module prt_panel_model (
  input  wire logic        pixel_clock,      // Clock
  input  wire logic        horizontal_sync,  // Line sync
  input  wire logic        vertical_sync,    // Frame sync
  input  wire logic        data_enable,      // Active pixel
  input  wire logic [23:0] rgb_data,         // Colour
  output var  logic [31:0] meas [9],         // Figures seen
  output var  logic        full              // Active line done
);
  timeunit 1ns;
  timeprecision 1ps;
  // Samples only on rising edges, as the panel does
  logic hp = 1'b0;
  logic vp = 1'b0;
  logic dp = 1'b0;
  logic s  = 1'b0;
  int   c  = 0;
  int   e  = 0;
  int   d  = 0;
  int   n  = 0;
  int   n0 = 0;
  initial full = 1'b0;
  always @(posedge pixel_clock) begin
    hp <= !horizontal_sync;
    vp <= !vertical_sync;
    dp <= data_enable;
    c  <= (!horizontal_sync && !hp) ? 1 : c + 1;
    e  <= (data_enable && !dp) ? 1 : e + 1;
    d  <= (!data_enable && dp) ? 1 : d + 1;
    if (!horizontal_sync && !hp) begin
      n       <= n + 1;
      meas[4] <= c;
      meas[3] <= d;
      full    <= s;
    end
    if (horizontal_sync && hp) meas[0] <= c;
    if (!vertical_sync && !vp) n0 <= n;
    if (vertical_sync && vp) meas[5] <= n - n0;
    if (data_enable && !dp) meas[1] <= c;
    if (data_enable && !dp && !s) begin
      s       <= 1'b1;
      meas[6] <= n - n0 - 1;
      meas[7] <= rgb_data;
    end
    if (!data_enable && dp) meas[2] <= e;
    if (data_enable) meas[8] <= rgb_data;
  end
endmodule : prt_panel_model
`default_nettype wire

// ### tb/tb_prt_host.sv
`default_nettype none
module tb_prt_host;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RST_CYC = 20;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        pix_valid = 1'b0;
  logic [23:0] pix_data = 24'h00_0000;
  logic [23:0] rgb_data;
  logic        pix_ready, pixel_clock, horizontal_sync, vertical_sync, data_enable, panel_reset_n, underrun, full;
  logic        frame_start;
  int          fs_n = 0;
  logic [31:0] meas [9];
  logic [31:0] exp_t [9] = '{30, 46, 800, 210, 1056, 13, 23, 0, 799};
  int          errors = 0;
  int          samples_checked = 0;
  int          taken = 0;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (pix_valid && pix_ready) taken <= taken + 1;
  always @(negedge core_clk) pix_data <= taken[23:0];
  always @(posedge core_clk) if (frame_start === 1'b1) fs_n <= fs_n + 1;
  prt_host #(.RESET_CYCLES(RST_CYC)) DUT (.core_clk, .rst_n, .pix_data, .pix_valid, .pix_ready, .pixel_clock,
    .horizontal_sync, .vertical_sync, .data_enable, .rgb_data, .panel_reset_n, .frame_start, .underrun);
  prt_panel_model u_panel (.pixel_clock, .horizontal_sync, .vertical_sync, .data_enable, .rgb_data, .meas, .full);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %0d expected %0d", $time, got, exp);
    end
  endtask : chk
  task automatic wait_hi(ref logic s, output int n);
    n = 0;
    while (s !== 1'b1 && n < 100000) begin
      @(negedge core_clk);
      n++;
    end
  endtask : wait_hi
  task automatic t_reset();
    int n;
    chk(panel_reset_n, 1'b0);
    chk(horizontal_sync & vertical_sync, 1'b1);
    wait_hi(panel_reset_n, n);
    chk(n >= RST_CYC && n < 100000, 1'b1);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_fifo();
    repeat (40) @(negedge core_clk);
    chk(pix_ready, 1'b0);
    chk(taken, 32);
    $display("t_fifo done");
  endtask : t_fifo
  task automatic t_frame();
    int n;
    wait_hi(full, n);
    for (int i = 0; i < 9; i++) chk(meas[i], exp_t[i]);
    chk(underrun, 1'b0);
    chk(fs_n, 1);
    $display("t_frame done");
  endtask : t_frame
  task automatic t_underrun();
    int n;
    n = 0;
    while (pix_ready !== 1'b1 && n < 10000) begin
      @(negedge core_clk);
      n++;
    end
    @(negedge core_clk);
    pix_valid = 1'b0;
    repeat (2 * 1056 * 3) @(negedge core_clk);
    chk(underrun, 1'b1);
    chk(meas[8], 0);
    $display("t_underrun done");
  endtask : t_underrun
  task automatic complete_run();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    pix_valid = 1'b1;
    t_reset();
    t_fifo();
    t_frame();
    t_underrun();
    complete_run();
  end
  initial begin
    #1_000_000;
    errors++;
    complete_run();
  end
endmodule : tb_prt_host
`default_nettype wire
